/* File: verilog/sec_consts.svh */
`ifndef SEC_CONSTS_SVH
`define SEC_CONSTS_SVH
// ==========================================
// timing
`define SEC_CLK_HZ 10000000
`define SEC_T_WR_US 1000
`define SEC_WR_CYCLES (`SEC_T_WR_US * (`SEC_CLK_HZ / 1000000))
// ==========================================
// select code and array geometry
`define SEC_TYPE_ARRAY 4'hA
`define SEC_TYPE_IDPG 4'hB
`define SEC_LOCK_DATA_BIT 1
`define SEC_PAGE_BYTES 16
`define SEC_ARRAY_BYTES 512
`define SEC_ERASED 8'hFF
// ==========================================
// register map
`define SEC_AXI_AW 4
`define SEC_CTRL_OFS 4'h0
`define SEC_STAT_OFS 4'h4
`define SEC_CTRL_EN_BIT 0
`define SEC_CTRL_EN_RST 1'b1
`define SEC_SR_BUSY_BIT 0
`define SEC_SR_LOCK_BIT 1
`define SEC_SR_IDSEL_BIT 2
`define SEC_SR_WP_BIT 3
`define SEC_SR_CNT_LSB 16
`define SEC_RESP_OKAY 2'h0
`define SEC_RESP_SLVERR 2'h2
`endif

/* File: verilog/sec_pkg.sv */
`default_nettype none
package sec_pkg;
    // ==========================================
    // link command states
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_SEL = 3'h1,
        S_ADDR = 3'h2,
        S_WDATA = 3'h3,
        S_RDATA = 3'h4
    } sec_state_t;
endpackage
`default_nettype wire

/* File: verilog/sec_link_sense.sv */
`timescale 1ns/1ps
`default_nettype none
module sec_link_sense #(
    parameter int N = 5
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // raw pins: bit 0 clock line, bit 1 data line
    input wire logic [N-1:0] pin_async,
    // synchronised levels
    output logic [N-1:0] pin_lvl,
    // link events, one cycle each
    output logic scl_rise,
    output logic scl_fall,
    output logic start_det,
    output logic stop_det
);
    // ==========================================
    // synchroniser
    logic [N-1:0] meta_ff;
    logic [N-1:0] sync_ff;
    logic [N-1:0] prev_ff;

    // reset to idle-high so no false start appears at release
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff <= {N{1'b1}};
            sync_ff <= {N{1'b1}};
            prev_ff <= {N{1'b1}};
        end else begin
            meta_ff <= pin_async;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // ==========================================
    // edges and bus conditions, all from the second stage onward
    assign pin_lvl = sync_ff;
    assign scl_rise = sync_ff[0] & ~prev_ff[0];
    assign scl_fall = ~sync_ff[0] & prev_ff[0];
    assign start_det = sync_ff[0] & prev_ff[0] & prev_ff[1] & ~sync_ff[1];
    assign stop_det = sync_ff[0] & prev_ff[0] & ~prev_ff[1] & sync_ff[1];
endmodule
`default_nettype wire

/* File: verilog/sec_engine.sv */
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sec_consts.svh"
// Function
// - write cycle only on slot-ten stop
// - busy: data line released, all ignored
// - after write, counter follows last byte
// - protect high: no write, data nacked
// - byte write: one acked data byte
// - page write: counter advances per byte
// - overflow wraps inside the same page
// - type 1011 writes the identification page
// - locked page: data nacked, unchanged
// - lock command makes page read-only until reset
// - polling: no ack while busy
// - reads ignore the protect input
// - counter plus one after each read
// - random read: address then repeated start
// - current read uses the address counter
// - page access loads shared counter position
// - sequential read wraps to zero
// - page read uses random read format
// - lock status: ack means unlocked
// - start clears partial command, stop idles
// - master nack in slot nine ends read
// - select: type, strap bits, msb, rw
// - mismatch: no ack, back to standby
module sec_engine #(
    parameter int WR_CYCLES = `SEC_WR_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // serial link, data line is open drain
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // straps and protect pin
    input wire logic write_protect_input,
    input wire logic chip_addr_strap_hi,
    input wire logic chip_addr_strap_lo,
    // axi4-lite write channels
    input wire logic [`SEC_AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read channels
    input wire logic [`SEC_AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int WCNT_W = $clog2(WR_CYCLES + 1);
    localparam logic [WCNT_W-1:0] WR_LAST = WCNT_W'(WR_CYCLES - 1);

    default clocking dcb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // ==========================================
    // pin sensing
    logic [4:0] pin_lvl;
    logic scl_rise, scl_fall, start_det, stop_det;
    logic sda_lvl, wp_lvl;
    logic [1:0] strap_lvl;

    sec_link_sense #(
        .N(5)
    ) u_sense (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .pin_async({chip_addr_strap_hi, chip_addr_strap_lo, write_protect_input, sda_in, scl_in}),
        .pin_lvl(pin_lvl),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .start_det(start_det),
        .stop_det(stop_det)
    );
    assign sda_lvl = pin_lvl[1];
    assign wp_lvl = pin_lvl[2];
    assign strap_lvl = pin_lvl[4:3];

    // ==========================================
    // state
    sec_pkg::sec_state_t state_ff;
    logic [3:0] bit_ff;
    logic ack_ff, oe_ff;
    logic [7:0] shreg_ff;
    logic id_sel_ff, lock_sel_ff, msb_ff;
    logic [8:0] cnt_ff;
    logic [`SEC_PAGE_BYTES-1:0] vld_ff;
    logic lock_pend_ff, locked_ff, busy_ff, enable_ff;
    logic [WCNT_W-1:0] wcnt_ff;
    logic [7:0] arr_mem [`SEC_ARRAY_BYTES];
    logic [7:0] idp_mem [`SEC_PAGE_BYTES];
    logic [7:0] pbuf_mem [`SEC_PAGE_BYTES];
    logic [7:0] rd_byte;
    logic rx_state, sel_match, wr_ok, commit;
    logic ev_start, ev_eval, ev_load, ev_store, ev_lock, ev_trig;

    // ==========================================
    // event decode
    assign rx_state = (state_ff == sec_pkg::S_SEL) || (state_ff == sec_pkg::S_ADDR)
        || (state_ff == sec_pkg::S_WDATA);
    // a busy or disabled device never leaves standby on a start
    assign ev_start = start_det && !busy_ff && enable_ff;
    assign ev_eval = scl_fall && rx_state && !ack_ff && (bit_ff == 4'h8);
    assign ev_load = scl_fall && ack_ff && (state_ff == sec_pkg::S_RDATA);
    // type, straps; bit 1 is the array msb, bit 0 the direction
    assign sel_match = ((shreg_ff[7:4] == `SEC_TYPE_ARRAY) || (shreg_ff[7:4] == `SEC_TYPE_IDPG))
        && (shreg_ff[3:2] == strap_lvl);
    // protect pin gates writes only, locked page gates page writes
    assign wr_ok = !wp_lvl && !(id_sel_ff && locked_ff);
    assign ev_store = ev_eval && (state_ff == sec_pkg::S_WDATA) && wr_ok
        && !(id_sel_ff && lock_sel_ff);
    assign ev_lock = ev_eval && (state_ff == sec_pkg::S_WDATA) && wr_ok && id_sel_ff
        && lock_sel_ff && shreg_ff[`SEC_LOCK_DATA_BIT];
    // only a stop right after a data byte ack slot, with something to commit
    assign ev_trig = stop_det && (state_ff == sec_pkg::S_WDATA) && (bit_ff == 4'h1)
        && !ack_ff && ((|vld_ff) || lock_pend_ff);
    assign commit = busy_ff && (wcnt_ff == WR_LAST);

    // read source follows the last select type
    always_comb begin
        rd_byte = id_sel_ff ? idp_mem[cnt_ff[3:0]] : arr_mem[cnt_ff];
    end

    // ==========================================
    // bit and byte sequencer
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= sec_pkg::S_IDLE;
            bit_ff <= 4'h0;
            ack_ff <= 1'b0;
            oe_ff <= 1'b0;
            shreg_ff <= 8'h00;
            id_sel_ff <= 1'b0;
            lock_sel_ff <= 1'b0;
            msb_ff <= 1'b0;
        end else if (ev_start) begin
            state_ff <= sec_pkg::S_SEL;
            bit_ff <= 4'h0;
            ack_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else if (stop_det || start_det) begin
            state_ff <= sec_pkg::S_IDLE;
            bit_ff <= 4'h0;
            ack_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else if (scl_rise) begin
            if (ack_ff) begin
                // master ack slot: high means no more bytes
                if ((state_ff == sec_pkg::S_RDATA) && sda_lvl) begin
                    state_ff <= sec_pkg::S_IDLE;
                    oe_ff <= 1'b0;
                end
            end else if ((state_ff != sec_pkg::S_IDLE) && (bit_ff < 4'h8)) begin
                bit_ff <= bit_ff + 4'h1;
                if (state_ff != sec_pkg::S_RDATA) begin
                    shreg_ff <= {shreg_ff[6:0], sda_lvl};
                end
            end
        end else if (scl_fall) begin
            if (ack_ff) begin
                ack_ff <= 1'b0;
                bit_ff <= 4'h0;
                if (state_ff == sec_pkg::S_RDATA) begin
                    // next byte goes out msb first, whatever the protect pin
                    shreg_ff <= rd_byte;
                    oe_ff <= ~rd_byte[7];
                end else begin
                    oe_ff <= 1'b0;
                end
            end else if (bit_ff == 4'h8) begin
                ack_ff <= 1'b1;
                unique case (state_ff)
                    sec_pkg::S_SEL: begin
                        if (sel_match) begin
                            oe_ff <= 1'b1;
                            id_sel_ff <= shreg_ff[4];
                            msb_ff <= shreg_ff[1];
                            state_ff <= shreg_ff[0] ? sec_pkg::S_RDATA : sec_pkg::S_ADDR;
                        end else begin
                            oe_ff <= 1'b0;
                            state_ff <= sec_pkg::S_IDLE;
                        end
                    end
                    sec_pkg::S_ADDR: begin
                        oe_ff <= 1'b1;
                        lock_sel_ff <= shreg_ff[7];
                        state_ff <= sec_pkg::S_WDATA;
                    end
                    sec_pkg::S_WDATA: begin
                        oe_ff <= wr_ok;
                    end
                    sec_pkg::S_RDATA: begin
                        oe_ff <= 1'b0;
                    end
                    sec_pkg::S_IDLE: begin
                        oe_ff <= 1'b0;
                    end
                endcase
            end else if ((state_ff == sec_pkg::S_RDATA) && (bit_ff != 4'h0)) begin
                shreg_ff <= {shreg_ff[6:0], 1'b0};
                oe_ff <= ~shreg_ff[6];
            end
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = oe_ff;

    busy_quiet_a: assert property (busy_ff |-> !oe_ff && state_ff == sec_pkg::S_IDLE)
        else $error("data line driven during write cycle");
    poll_nack_a: assert property (busy_ff && start_det |=> state_ff == sec_pkg::S_IDLE)
        else $error("start taken while busy");
    sel_miss_a: assert property (ev_eval && state_ff == sec_pkg::S_SEL && !sel_match
        |=> !oe_ff && state_ff == sec_pkg::S_IDLE)
        else $error("mismatched select acknowledged");
    wp_nack_a: assert property (ev_eval && state_ff == sec_pkg::S_WDATA && wp_lvl
        |=> !oe_ff && !$changed(vld_ff))
        else $error("protected data byte acknowledged");
    lock_nack_a: assert property (ev_eval && state_ff == sec_pkg::S_WDATA
        && id_sel_ff && locked_ff |=> !oe_ff)
        else $error("locked page byte acknowledged");
    rd_stop_a: assert property (state_ff == sec_pkg::S_RDATA && ack_ff && scl_rise
        && sda_lvl |=> state_ff == sec_pkg::S_IDLE ##1 !oe_ff)
        else $error("read continued after master nack");

    // ==========================================
    // shared address counter
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff <= 9'h000;
        end else if (ev_eval && state_ff == sec_pkg::S_ADDR) begin
            // page access keeps only the byte position
            cnt_ff <= id_sel_ff ? {5'h00, shreg_ff[3:0]} : {msb_ff, shreg_ff};
        end else if (ev_store) begin
            cnt_ff <= {cnt_ff[8:4], cnt_ff[3:0] + 4'h1};
        end else if (ev_load) begin
            cnt_ff <= cnt_ff + 9'h001;
        end
    end

    rd_inc_a: assert property (ev_load |=> cnt_ff == $past(cnt_ff) + 9'h001)
        else $error("counter not advanced after read byte");
    page_wrap_a: assert property (ev_store |=> cnt_ff[8:4] == $past(cnt_ff[8:4]))
        else $error("write left its page");
    wr_keep_a: assert property (commit |=> cnt_ff == $past(cnt_ff))
        else $error("counter moved at write commit");

    // ==========================================
    // pending page buffer marks; a new start or address drops them
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            vld_ff <= '0;
            lock_pend_ff <= 1'b0;
        end else if (ev_start || (ev_eval && state_ff == sec_pkg::S_ADDR) || commit) begin
            vld_ff <= '0;
            lock_pend_ff <= 1'b0;
        end else begin
            if (ev_store) begin
                vld_ff[cnt_ff[3:0]] <= 1'b1;
            end
            if (ev_lock) begin
                lock_pend_ff <= 1'b1;
            end
        end
    end

    // ==========================================
    // internal write cycle timer
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            busy_ff <= 1'b0;
            wcnt_ff <= '0;
        end else if (ev_trig) begin
            busy_ff <= 1'b1;
            wcnt_ff <= '0;
        end else if (busy_ff) begin
            if (wcnt_ff == WR_LAST) begin
                busy_ff <= 1'b0;
            end else begin
                wcnt_ff <= wcnt_ff + 1'b1;
            end
        end
    end

    // lock survives until reset here; only reset_n clears it
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            locked_ff <= 1'b0;
        end else if (commit && lock_pend_ff) begin
            locked_ff <= 1'b1;
        end
    end

    trig_slot_a: assert property ($rose(busy_ff) |-> $past(stop_det
        && state_ff == sec_pkg::S_WDATA && bit_ff == 4'h1 && !ack_ff))
        else $error("write cycle started outside slot ten");
    busy_len_a: assert property ($fell(busy_ff) |-> $past(wcnt_ff) == WR_LAST)
        else $error("write cycle length wrong");
    lock_keep_a: assert property (locked_ff |=> locked_ff)
        else $error("page lock cleared");

    // ==========================================
    // storage; commit writes every marked byte of the page at once
    initial begin
        for (int i = 0; i < `SEC_ARRAY_BYTES; i++) begin
            arr_mem[i] = `SEC_ERASED;
        end
        for (int i = 0; i < `SEC_PAGE_BYTES; i++) begin
            idp_mem[i] = `SEC_ERASED;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (ev_store) begin
            pbuf_mem[cnt_ff[3:0]] <= shreg_ff;
        end
        if (commit) begin
            for (int i = 0; i < `SEC_PAGE_BYTES; i++) begin
                if (vld_ff[i] && id_sel_ff) begin
                    idp_mem[i] <= pbuf_mem[i];
                end else if (vld_ff[i]) begin
                    arr_mem[{cnt_ff[8:4], 4'(i)}] <= pbuf_mem[i];
                end
            end
        end
    end

    // ==========================================
    // axi4-lite slave, one write and one read outstanding
    logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
    logic [`SEC_AXI_AW-1:0] awaddr_ff;
    logic wbit_ff, wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;

    assign s_axi_awready = !aw_got_ff;
    assign s_axi_wready = !w_got_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // address and data are held until both arrived and the response slot is free
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= '0;
            wbit_ff <= 1'b0;
            wstrb_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `SEC_RESP_OKAY;
            enable_ff <= `SEC_CTRL_EN_RST;
        end else begin
            if (s_axi_awvalid && !aw_got_ff) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_got_ff) begin
                w_got_ff <= 1'b1;
                wbit_ff <= s_axi_wdata[`SEC_CTRL_EN_BIT];
                wstrb_ff <= s_axi_wstrb[0];
            end
            if (aw_got_ff && w_got_ff && !bvalid_ff) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= `SEC_RESP_OKAY;
                if (awaddr_ff == `SEC_CTRL_OFS) begin
                    if (wstrb_ff) begin
                        enable_ff <= wbit_ff;
                    end
                end else if (awaddr_ff != `SEC_STAT_OFS) begin
                    bresp_ff <= `SEC_RESP_SLVERR;
                end
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // read answer registered one cycle after the address handshake
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `SEC_RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `SEC_RESP_OKAY;
            if (s_axi_araddr == `SEC_CTRL_OFS) begin
                rdata_ff[`SEC_CTRL_EN_BIT] <= enable_ff;
            end else if (s_axi_araddr == `SEC_STAT_OFS) begin
                rdata_ff[`SEC_SR_BUSY_BIT] <= busy_ff;
                rdata_ff[`SEC_SR_LOCK_BIT] <= locked_ff;
                rdata_ff[`SEC_SR_IDSEL_BIT] <= id_sel_ff;
                rdata_ff[`SEC_SR_WP_BIT] <= wp_lvl;
                rdata_ff[`SEC_SR_CNT_LSB +: 9] <= cnt_ff;
            end else begin
                rresp_ff <= `SEC_RESP_SLVERR;
            end
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ==========================================
    // main scenarios
    wr_cycle_c: cover property (ev_trig ##1 busy_ff);
    lock_set_c: cover property (ev_lock);
    seq_read_c: cover property (ev_load ##[1:200] ev_load);
    sel_miss_c: cover property (ev_eval && state_ff == sec_pkg::S_SEL && !sel_match);
endmodule
`default_nettype wire

/* File: tb/sec_bus_mst.sv */
`timescale 1ns/1ps
`default_nettype none
module sec_bus_mst (
    // link pins
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    // quarter of the 800 ns link period; data moves a quarter after the fall
    localparam int Q = 200;
    // clock stands still high between frames
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // start also serves as repeated start and clears a half-sent command
    task automatic start();
        sda_pull = 1'b0;
        #(2*Q) scl = 1'b1;
        #(2*Q) sda_pull = 1'b1;
        #(2*Q) scl = 1'b0;
        #Q;
    endtask
    // stop returns the link to standby
    task automatic stop();
        sda_pull = 1'b1;
        #(2*Q) scl = 1'b1;
        #(2*Q) sda_pull = 1'b0;
        #(2*Q);
    endtask
    // one clock pulse, line sampled mid high
    task automatic pulse(output logic b);
        #Q scl = 1'b1;
        #Q b = sda;
        #Q scl = 1'b0;
        #Q;
    endtask
    // send a byte msb first, return the acknowledge
    task automatic wb(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            sda_pull = !d[i];
            pulse(b);
        end
        sda_pull = 1'b0;
        pulse(b);
        ack = !b;
    endtask
    // receive a byte; no acknowledge on the last one
    task automatic rb(input logic last, output logic [7:0] d);
        logic b;
        sda_pull = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            pulse(b);
            d[i] = b;
        end
        sda_pull = !last;
        pulse(b);
        sda_pull = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: tb/sec_engine_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module sec_engine_bench;
    // ==========================================
    // signals
    logic clk_sys, reset_n, write_protect_input, chip_addr_strap_hi, chip_addr_strap_lo;
    logic awvalid, wvalid, bready, arvalid, rready, ack;
    logic [3:0] awaddr, araddr;
    logic [31:0] wdata, d32;
    logic [1:0] r2;
    logic [8:0] a;
    wire awready, wready, bvalid, arready, rvalid, sda_out, sda_oe, scl, m_pull;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int mismatches, comparisons, cycles;
    integer seed = 32'h5b48;
    logic [7:0] mem [512];
    logic [7:0] idp [16];
    // open-drain data line with pull-up
    wire sda = (sda_oe ? sda_out : 1'b1) && !m_pull;
    // short write cycle, brief polls
    sec_engine #(.WR_CYCLES(200)) i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .write_protect_input(write_protect_input), .chip_addr_strap_hi(chip_addr_strap_hi),
        .chip_addr_strap_lo(chip_addr_strap_lo), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    sec_bus_mst i_mst (.scl(scl), .sda_pull(m_pull), .sda(sda));
    // clock and hang guard
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = !clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            summarize();
        end
    end
    // ==========================================
    // checks and bus tasks
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_ack(input string n, input logic e, input logic g);
        chk(n, {31'h0, e}, {31'h0, g});
    endtask
    task automatic summarize();
        if (mismatches == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic axw(input logic [3:0] ad, input logic [31:0] dt, output logic [1:0] r);
        @(posedge clk_sys);
        awaddr <= ad;
        wdata <= dt;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [3:0] ad, output logic [31:0] dt, output logic [1:0] r);
        @(posedge clk_sys);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        dt = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    function automatic logic [7:0] sel(input logic [3:0] ty, input logic a8, input logic rw);
        return {ty, chip_addr_strap_hi, chip_addr_strap_lo, a8, rw};
    endfunction
    // write n bytes; ok says whether they should be acked and stored
    task automatic put(input logic [3:0] ty, input logic [8:0] ad, input int n, input logic ok,
            input logic [7:0] om);
        logic [7:0] d;
        int k;
        i_mst.start();
        i_mst.wb(sel(ty, ad[8], 1'b0), ack);
        chk_ack("wsel", 1'b1, ack);
        i_mst.wb(ad[7:0], ack);
        chk_ack("waddr", 1'b1, ack);
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed)) | om;
            i_mst.wb(d, ack);
            chk_ack("wdata", ok, ack);
            if (ok && !(ty[0] && ad[7])) begin
                if (ty[0]) idp[ad[3:0]] = d;
                else mem[ad] = d;
            end
            ad[3:0] = ad[3:0] + 4'h1;
        end
        i_mst.stop();
        k = 0;
        ack = 1'b0;
        while (!ack && k < 20) begin
            i_mst.start();
            i_mst.wb(sel(4'hA, 1'b0, 1'b0), ack);
            i_mst.stop();
            if (k == 0) chk_ack("busy", !ok, ack);
            k++;
        end
        chk_ack("ready", 1'b1, ack);
    endtask
    // read n bytes, optionally setting the address first
    task automatic get(input logic [3:0] ty, input logic [8:0] ad, input int n, input logic rnd);
        logic [7:0] d;
        i_mst.start();
        if (rnd) begin
            i_mst.wb(sel(ty, ad[8], 1'b0), ack);
            i_mst.wb(ad[7:0], ack);
            chk_ack("raddr", 1'b1, ack);
            i_mst.start();
        end
        i_mst.wb(sel(ty, ad[8], 1'b1), ack);
        chk_ack("rsel", 1'b1, ack);
        for (int i = 0; i < n; i++) begin
            i_mst.rb(i == n - 1, d);
            chk("rdata", {24'h0, ty[0] ? idp[ad[3:0]] : mem[ad]}, {24'h0, d});
            ad = ad + 9'h1;
        end
        i_mst.stop();
    endtask
    // one data byte, then start and stop discard the command
    task automatic trunc(input logic [3:0] ty, input logic [8:0] ad, input logic e);
        i_mst.start();
        i_mst.wb(sel(ty, ad[8], 1'b0), ack);
        i_mst.wb(ad[7:0], ack);
        i_mst.wb(8'($random(seed)), ack);
        chk_ack("tack", e, ack);
        i_mst.start();
        i_mst.stop();
    endtask
    // ==========================================
    // main sequence
    initial begin
        {reset_n, write_protect_input, chip_addr_strap_lo, awvalid, wvalid, bready} = 6'h0;
        {arvalid, rready, awaddr, araddr, wdata} = 42'h0;
        chip_addr_strap_hi = 1'b1;
        foreach (mem[i]) mem[i] = 8'hFF;
        foreach (idp[i]) idp[i] = 8'hFF;
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        axr(4'h0, d32, r2);
        chk("ctrl", 32'h1, d32);
        axw(4'h8, 32'h0, r2);
        chk("bresp", 32'h2, {30'h0, r2});
        a = 9'($random(seed));
        a[0] = 1'b0;
        put(4'hA, a, 1, 1'b1, 8'h00);
        get(4'hA, a + 9'h1, 2, 1'b0);
        get(4'hA, a, 1, 1'b1);
        a[3:0] = 4'hE;
        put(4'hA, a, 18, 1'b1, 8'h00);
        get(4'hA, {a[8:4], 4'h0}, 16, 1'b1);
        get(4'hA, 9'h1FE, 4, 1'b1);
        @(posedge clk_sys) write_protect_input <= 1'b1;
        put(4'hA, a, 3, 1'b0, 8'h00);
        get(4'hA, a, 3, 1'b1);
        @(posedge clk_sys) write_protect_input <= 1'b0;
        trunc(4'hA, a, 1'b1);
        get(4'hA, a, 1, 1'b1);
        for (int i = 0; i < 2; i++) begin
            i_mst.start();
            i_mst.wb(sel(4'hA, 1'b0, 1'b0) ^ (i ? 8'h40 : 8'h08), ack);
            chk_ack("nsel", 1'b0, ack);
            i_mst.stop();
        end
        axw(4'h0, 32'h0, r2);
        trunc(4'hA, a, 1'b0);
        axw(4'h0, 32'h1, r2);
        a = 9'($random(seed));
        a[7] = 1'b0;
        put(4'hB, a, 3, 1'b1, 8'h00);
        get(4'hB, {a[8:4], 4'h0}, 16, 1'b1);
        trunc(4'hB, 9'h000, 1'b1);
        put(4'hB, 9'h080, 1, 1'b1, 8'h02);
        trunc(4'hB, 9'h000, 1'b0);
        put(4'hB, a, 2, 1'b0, 8'h00);
        get(4'hB, {a[8:4], 4'h0}, 16, 1'b1);
        axr(4'h4, d32, r2);
        chk("locked", 32'h1, {31'h0, d32[1]});
        summarize();
    end
endmodule
`default_nettype wire
